// >>> psp_port_page.sv
// Per-port status and control register page of a multi-port cable PHY
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "psp_cfg.svh"
module psp_port_page #(
    parameter int NPORTS = 3,
    parameter int DEBOUNCE_TICKS = `PSP_DEBOUNCE_TICKS,
    parameter int BIAS_TICKS = `PSP_BIAS_TICKS
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input psp_pkg::psp_addr_type addr,
    input psp_pkg::psp_data_type wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output psp_pkg::psp_data_type rd_data,
    input wire logic bus_reset,
    input wire logic tree_id_done,
    input wire logic [2*NPORTS-1:0] pair_a,
    input wire logic [2*NPORTS-1:0] pair_b,
    input wire logic [NPORTS-1:0] child_role,
    input wire logic [NPORTS-1:0] suspended,
    input wire logic [NPORTS-1:0] fast_link_mode,
    input wire logic [NPORTS-1:0] conn_detect,
    input wire logic [NPORTS-1:0] tones_seen,
    input wire logic [NPORTS-1:0] speed_neg_done,
    input wire logic [3*NPORTS-1:0] neg_speed,
    input wire logic [NPORTS-1:0] self_id_strobe,
    input wire logic [3*NPORTS-1:0] self_id_speed,
    input wire logic [NPORTS-1:0] bias_input,
    input wire logic [NPORTS-1:0] signal_valid,
    input wire logic [NPORTS-1:0] tones_only,
    input wire logic [NPORTS-1:0] dc_detect,
    input wire logic [NPORTS-1:0] port_event,
    input wire logic port_event_ack,
    input wire logic [NPORTS-1:0] resume_fault,
    input wire logic [NPORTS-1:0] suspend_fault,
    input wire logic [NPORTS-1:0] standby_error,
    input wire logic [NPORTS-1:0] in_standby,
    input wire logic [NPORTS-1:0] remote_standby_clear,
    output logic [NPORTS-1:0] port_off_control,
    output logic [NPORTS-1:0] scrambler_off,
    output logic [NPORTS-1:0] hold_suspended,
    output logic [NPORTS-1:0] standby_err_clear,
    output logic port_event_irq_flag,
    output logic child_flag_valid
);
    import psp_pkg::*;

    localparam int CW = $clog2(DEBOUNCE_TICKS + 1);
    localparam int BW = $clog2(BIAS_TICKS + 1) + 1;

    typedef struct packed {
        logic [7:0] rd_data;
        logic [2:0] page_sel;
        logic [3:0] port_sel;
        logic [NPORTS-1:0] port_off;
        logic [NPORTS-1:0] irq_en;
        logic [NPORTS-1:0] fault;
        logic [NPORTS-1:0] sb_fault;
        logic [NPORTS-1:0] scr_off;
        logic [NPORTS-1:0] sb_clr;
        logic [NPORTS-1:0] prev_conn;
        logic [NPORTS-1:0] prev_standby;
        logic [3*NPORTS-1:0] speed;
        logic child_known;
        logic irq_flag;
    } psp_page_state_type;

    psp_page_state_type q;
    psp_page_state_type next_q;

    logic tick;
    logic [NPORTS-1:0] conn_raw;
    logic [NPORTS-1:0] conn_db;
    logic [NPORTS-1:0] bias_db;

    psp_tick #(
        .DIV(`PSP_TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(tick)
    );

    // Each port gets its own debouncers so ports settle independently
    for (genvar g = 0; g < NPORTS; g++) begin : g_port
        // Fast mode counts as connected only with tones plus negotiation
        assign conn_raw[g] = fast_link_mode[g] ?
            (tones_seen[g] & speed_neg_done[g]) : conn_detect[g];

        psp_debounce #(
            .TICKS(DEBOUNCE_TICKS),
            .CW(CW)
        ) u_conn_deb (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .tick(tick),
            .raw(conn_raw[g]),
            .stable(conn_db[g])
        );

        psp_debounce #(
            .TICKS(BIAS_TICKS),
            .CW(BW)
        ) u_bias_deb (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .tick(tick),
            .raw(bias_input[g]),
            .stable(bias_db[g])
        );
    end

    logic page_hit;
    logic [NPORTS-1:0] sel_hit;
    logic wr_line;
    logic wr_ctrl;
    logic child_rd;
    logic receive_valid_rd;
    logic [2:0] nspd;
    logic [2:0] lspd;
    logic [7:0] line_rd;
    logic [7:0] ctrl_rd;
    logic [7:0] dc_rd;

    always_comb begin
        next_q = q;
        page_hit = (q.page_sel == `PSP_PAGE_PORT);
        wr_line = wr_en && page_hit && (addr == `PSP_ADDR_LINE);
        wr_ctrl = wr_en && page_hit && (addr == `PSP_ADDR_CTRL);
        line_rd = 8'h00;
        ctrl_rd = 8'h00;
        dc_rd = 8'h00;
        child_rd = 1'b0;
        receive_valid_rd = 1'b0;
        nspd = 3'h0;
        lspd = 3'h0;
        sel_hit = '0;
        next_q.sb_clr = '0;

        // Tree identification gates the child bit's validity
        if (bus_reset) begin
            next_q.child_known = 1'b0;
        end else if (tree_id_done) begin
            next_q.child_known = 1'b1;
        end

        // Select register; other pages are outside this block
        if (wr_en && (addr == `PSP_ADDR_SELECT)) begin
            next_q.page_sel = wr_data[`PSP_SEL_PAGE_HI:`PSP_SEL_PAGE_LO];
            next_q.port_sel = wr_data[`PSP_SEL_PORT_HI:`PSP_SEL_PORT_LO];
        end

        // A port number beyond the last port matches nothing
        for (int i = 0; i < NPORTS; i++) begin
            sel_hit[i] = (q.port_sel == 4'(i));
        end

        for (int i = 0; i < NPORTS; i++) begin
            // Software writes reach only the selected port
            if (wr_line && sel_hit[i]) begin
                next_q.port_off[i] = wr_data[`PSP_LINE_DIS];
            end
            if (wr_ctrl && sel_hit[i]) begin
                next_q.irq_en[i] = wr_data[`PSP_CTRL_IRQEN];
                next_q.scr_off[i] = wr_data[`PSP_CTRL_SCROFF];
                if (wr_data[`PSP_CTRL_FAULT]) begin
                    next_q.fault[i] = 1'b0;
                end
                if (wr_data[`PSP_CTRL_SBFAULT] && q.sb_fault[i]) begin
                    next_q.sb_fault[i] = 1'b0;
                    next_q.sb_clr[i] = 1'b1;
                end
            end

            // Remote command clear acts like a software clear
            if (remote_standby_clear[i] && q.sb_fault[i]) begin
                next_q.sb_fault[i] = 1'b0;
                next_q.sb_clr[i] = 1'b1;
            end

            // Leaving standby drops the fault without a clear pulse
            next_q.prev_standby[i] = in_standby[i];
            if (q.prev_standby[i] && !in_standby[i]) begin
                next_q.sb_fault[i] = 1'b0;
            end

            // Hardware sets win over any clear in the same cycle
            if (standby_error[i]) begin
                next_q.sb_fault[i] = 1'b1;
            end
            if (resume_fault[i] || suspend_fault[i]) begin
                next_q.fault[i] = 1'b1;
            end

            // Agreed speed; reserved codes never overwrite a good value
            next_q.prev_conn[i] = conn_db[i];
            nspd = neg_speed[3*i +: 3];
            lspd = self_id_speed[3*i +: 3];
            if (fast_link_mode[i] && conn_db[i] && !q.prev_conn[i]
                && (nspd < `PSP_SPEED_RSVD_LO)) begin
                next_q.speed[3*i +: 3] = nspd;
            end else if (!fast_link_mode[i] && self_id_strobe[i]
                && (lspd <= `PSP_SPEED_800)) begin
                next_q.speed[3*i +: 3] = lspd;
            end
        end

        // Link event flag; a new event wins over the link's acknowledge
        if (port_event_ack) begin
            next_q.irq_flag = 1'b0;
        end
        if (|(port_event & q.irq_en)) begin
            next_q.irq_flag = 1'b1;
        end

        // Read side, built from the selected port only
        for (int i = 0; i < NPORTS; i++) begin
            if (sel_hit[i]) begin
                // Unknown role or an idle port is shown as a child
                child_rd = !q.child_known || child_role[i] || !conn_db[i]
                    || q.port_off[i] || suspended[i];
                receive_valid_rd = fast_link_mode[i] ?
                    (signal_valid[i] && !tones_only[i]) : bias_db[i];
                line_rd[`PSP_LINE_A_HI:`PSP_LINE_A_LO] =
                    pair_a[2*i +: 2];
                line_rd[`PSP_LINE_B_HI:`PSP_LINE_B_LO] =
                    pair_b[2*i +: 2];
                line_rd[`PSP_LINE_CH] = child_rd;
                line_rd[`PSP_LINE_CON] = conn_db[i];
                line_rd[`PSP_LINE_RECEIVE_VALID] = receive_valid_rd;
                line_rd[`PSP_LINE_DIS] = q.port_off[i];
                ctrl_rd[`PSP_CTRL_SPD_HI:`PSP_CTRL_SPD_LO] =
                    q.speed[3*i +: 3];
                ctrl_rd[`PSP_CTRL_IRQEN] = q.irq_en[i];
                ctrl_rd[`PSP_CTRL_FAULT] = q.fault[i];
                ctrl_rd[`PSP_CTRL_SBFAULT] = q.sb_fault[i];
                ctrl_rd[`PSP_CTRL_SCROFF] = q.scr_off[i];
                ctrl_rd[`PSP_CTRL_FASTONLY] = `PSP_FAST_ONLY_VALUE;
                dc_rd[`PSP_DC_SEEN] = dc_detect[i];
            end
        end

        // Read data stand for one cycle only, zero otherwise
        next_q.rd_data = 8'h00;
        if (rd_en) begin
            case (addr)
                `PSP_ADDR_SELECT: begin
                    next_q.rd_data[`PSP_SEL_PAGE_HI:`PSP_SEL_PAGE_LO] =
                        q.page_sel;
                    next_q.rd_data[`PSP_SEL_PORT_HI:`PSP_SEL_PORT_LO] =
                        q.port_sel;
                end
                `PSP_ADDR_LINE: begin
                    next_q.rd_data = page_hit ? line_rd : 8'h00;
                end
                `PSP_ADDR_CTRL: begin
                    next_q.rd_data = page_hit ? ctrl_rd : 8'h00;
                end
                `PSP_ADDR_DC: begin
                    next_q.rd_data = page_hit ? dc_rd : 8'h00;
                end
                default: begin
                    next_q.rd_data = 8'h00;
                end
            endcase
        end
    end

    // Bus reset is an input here, never a reset: persistent bits keep value
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign rd_data = q.rd_data;
    assign port_off_control = q.port_off;
    assign scrambler_off = q.scr_off;
    assign hold_suspended = q.fault;
    assign standby_err_clear = q.sb_clr;
    assign port_event_irq_flag = q.irq_flag;
    assign child_flag_valid = q.child_known;
endmodule : psp_port_page

// >>> psp_cfg.svh
// Offsets, field positions, reset values and timing counts of the port page
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH

// Register addresses on the plain register port
`define PSP_ADDR_SELECT 4'h7
`define PSP_ADDR_LINE 4'h8
`define PSP_ADDR_CTRL 4'h9
`define PSP_ADDR_DC 4'ha

// Page that holds the per-port status registers
`define PSP_PAGE_PORT 3'h0

// Select register: page in the top bits, port in the low nibble
`define PSP_SEL_PAGE_HI 7
`define PSP_SEL_PAGE_LO 5
`define PSP_SEL_PORT_HI 3
`define PSP_SEL_PORT_LO 0

// Line-state register fields
`define PSP_LINE_A_HI 7
`define PSP_LINE_A_LO 6
`define PSP_LINE_B_HI 5
`define PSP_LINE_B_LO 4
`define PSP_LINE_CH 3
`define PSP_LINE_CON 2
`define PSP_LINE_RECEIVE_VALID 1
`define PSP_LINE_DIS 0

// Control register fields
`define PSP_CTRL_SPD_HI 7
`define PSP_CTRL_SPD_LO 5
`define PSP_CTRL_IRQEN 4
`define PSP_CTRL_FAULT 3
`define PSP_CTRL_SBFAULT 2
`define PSP_CTRL_SCROFF 1
`define PSP_CTRL_FASTONLY 0

// Dc-connection register field
`define PSP_DC_SEEN 7

// Fixed read values and reset values
`define PSP_FAST_ONLY_VALUE 1'h0
`define PSP_RESET_SPEED 3'h0
`define PSP_SPEED_LOWEST 3'h0
`define PSP_SPEED_800 3'h3
`define PSP_SPEED_RSVD_LO 3'h6

// Timing: clock rate, tick period and connection debounce time
`define PSP_CLK_MHZ 250
`define PSP_TICK_US 1
`define PSP_TICK_CYCLES (`PSP_CLK_MHZ * `PSP_TICK_US)
`define PSP_DEBOUNCE_MS 341
`define PSP_DEBOUNCE_TICKS ((`PSP_DEBOUNCE_MS * 1000) / `PSP_TICK_US)
`define PSP_BIAS_TICKS 1

`endif

// >>> psp_pkg.sv
// Types shared by the port status page modules
package psp_pkg;
    typedef logic [3:0] psp_addr_type;
    typedef logic [7:0] psp_data_type;
    typedef logic [2:0] psp_speed_type;
    typedef logic [1:0] psp_line_type;
endpackage : psp_pkg

// >>> psp_tick.sv
// Divider that yields a one-cycle timing tick
`timescale 1ns/1ps
module psp_tick #(
    parameter int DIV = 250
) (
    input wire logic ref_clk,
    input wire logic nrst,
    output logic tick
);
    import psp_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } psp_tick_state_type;

    psp_tick_state_type q;
    psp_tick_state_type next_q;

    always_comb begin
        next_q = q;
        next_q.tick = 1'b0;
        if (q.count == 16'(DIV - 1)) begin
            next_q.count = 16'h0000;
            next_q.tick = 1'b1;
        end else begin
            next_q.count = q.count + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tick = q.tick;
endmodule : psp_tick

// >>> psp_debounce.sv
// Rise debouncer: output goes high only after the input has held for a time
`timescale 1ns/1ps
module psp_debounce #(
    parameter int TICKS = 341000,
    parameter int CW = 20
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic raw,
    output logic stable
);
    import psp_pkg::*;

    typedef struct packed {
        logic [CW-1:0] count;
        logic stable;
    } psp_deb_state_type;

    psp_deb_state_type q;
    psp_deb_state_type next_q;

    // A drop is reported at once; only the rise waits out the interval
    always_comb begin
        next_q = q;
        if (!raw) begin
            next_q.count = '0;
            next_q.stable = 1'b0;
        end else if (!q.stable && tick) begin
            if (q.count >= CW'(TICKS - 1)) begin
                next_q.stable = 1'b1;
            end else begin
                next_q.count = q.count + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign stable = q.stable;
endmodule : psp_debounce

// >>> psp_peer.sv
// Peer physical layer model standing at the far end of each cable port
`timescale 1ns/1ps
module psp_peer #(
    parameter int N = 3,
    parameter int NEG_DELAY = 40
) (
    input wire logic ref_clk,
    input wire logic [N-1:0] plug,
    input wire logic [N-1:0] fast,
    input wire logic [2*N-1:0] line_code,
    input wire logic [3*N-1:0] offer_speed,
    output logic [2*N-1:0] pair_a,
    output logic [2*N-1:0] pair_b,
    output logic [N-1:0] conn_detect,
    output logic [N-1:0] tones_seen,
    output logic [N-1:0] speed_neg_done,
    output logic [3*N-1:0] neg_speed,
    output logic [N-1:0] bias_input,
    output logic [N-1:0] signal_valid,
    output logic [N-1:0] tones_only,
    output logic [N-1:0] dc_detect
);
    int cnt [N];
    // Negotiation takes NEG_DELAY cycles, so early reads see tones only
    always @(posedge ref_clk) begin
        for (int i = 0; i < N; i++) begin
            if (!(plug[i] && fast[i]))
                cnt[i] <= 0;
            else if (cnt[i] < NEG_DELAY)
                cnt[i] <= cnt[i] + 1;
        end
    end
    always_comb begin
        for (int i = 0; i < N; i++) begin
            tones_seen[i] = plug[i] && fast[i];
            speed_neg_done[i] = tones_seen[i] && cnt[i] == NEG_DELAY;
            // Reserved code until agreed, never a stale speed
            neg_speed[3*i+:3] = speed_neg_done[i] ? offer_speed[3*i+:3] : 3'h7;
            tones_only[i] = tones_seen[i] && !speed_neg_done[i];
            signal_valid[i] = speed_neg_done[i];
            conn_detect[i] = plug[i] && !fast[i];
            dc_detect[i] = conn_detect[i];
            bias_input[i] = plug[i];
            pair_a[2*i+:2] = line_code[2*i+:2];
            pair_b[2*i+:2] = {line_code[2*i], line_code[2*i+1]};
        end
    end
endmodule : psp_peer

// >>> psp_port_page_sva.sv
// Checker for the port page, bound to its ports
`timescale 1ns/1ps
module psp_port_page_sva #(
    parameter int NPORTS = 3
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input psp_pkg::psp_addr_type addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input psp_pkg::psp_data_type rd_data,
    input wire logic bus_reset,
    input wire logic tree_id_done,
    input wire logic [NPORTS-1:0] port_event,
    input wire logic [NPORTS-1:0] resume_fault,
    input wire logic [NPORTS-1:0] suspend_fault,
    input wire logic [NPORTS-1:0] remote_standby_clear,
    input wire logic [NPORTS-1:0] port_off_control,
    input wire logic [NPORTS-1:0] scrambler_off,
    input wire logic [NPORTS-1:0] hold_suspended,
    input wire logic [NPORTS-1:0] standby_err_clear,
    input wire logic port_event_irq_flag,
    input wire logic child_flag_valid
);
    import psp_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    AST_RD_IDLE: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    AST_RD_UNMAP: assert property (rd_en && (addr < 4'h7 || addr > 4'ha)
        |=> rd_data == 8'h00) else $error("unmapped read not zero");
    AST_IRQ_SET: assert property ($rose(port_event_irq_flag)
        |-> $past(|port_event)) else $error("event flag rose without event");
    AST_CHILD_INV: assert property (bus_reset |=> !child_flag_valid)
        else $error("child flag valid after bus reset");
    AST_CHILD_VAL: assert property (tree_id_done && !bus_reset
        |=> child_flag_valid) else $error("child flag not valid");
    AST_FAULT_SET: assert property (|(resume_fault | suspend_fault)
        |=> ($past(resume_fault | suspend_fault) & ~hold_suspended) == '0)
        else $error("fault did not hold port suspended");
    AST_CTRL_HOLD: assert property (!wr_en
        |=> $stable(port_off_control) && $stable(scrambler_off))
        else $error("control bits changed without write");
    AST_STBY_CAUSE: assert property (|standby_err_clear
        |-> $past(wr_en) || $past(|remote_standby_clear))
        else $error("standby clear pulse without cause");
endmodule : psp_port_page_sva
bind psp_port_page psp_port_page_sva #(.NPORTS(NPORTS)) psp_port_page_sva_inst (
    .ref_clk, .nrst, .addr, .rd_en, .wr_en, .rd_data, .bus_reset, .tree_id_done,
    .port_event, .resume_fault, .suspend_fault, .remote_standby_clear,
    .port_off_control, .scrambler_off, .hold_suspended, .standby_err_clear,
    .port_event_irq_flag, .child_flag_valid);

// >>> test_psp_port_page.sv
// Self-checking bench for the per-port status and control page
`timescale 1ns/1ps
module test_psp_port_page;
    import psp_pkg::*;
    localparam int N = 3;
    localparam int CEIL = 20000;
    logic ref_clk, nrst, wr_en, rd_en, bus_reset, tree_id_done, port_event_ack;
    psp_addr_type addr;
    psp_data_type wr_data, rd_data;
    logic [N-1:0] child_role, suspended, fast_link_mode, self_id_strobe, plug;
    logic [N-1:0] port_event, resume_fault, suspend_fault, standby_error;
    logic [N-1:0] in_standby, remote_standby_clear, port_off_control;
    logic [N-1:0] scrambler_off, hold_suspended, standby_err_clear, dc_detect;
    logic [N-1:0] conn_detect, tones_seen, speed_neg_done, bias_input;
    logic [N-1:0] signal_valid, tones_only;
    logic [3*N-1:0] self_id_speed, neg_speed, offer_speed;
    logic [2*N-1:0] pair_a, pair_b, line_code;
    logic port_event_irq_flag, child_flag_valid;
    int num_errors, total_checks, cycles, clr_seen;

    psp_peer #(.N(N), .NEG_DELAY(40)) psp_peer_inst (.ref_clk, .plug,
        .fast(fast_link_mode), .line_code, .offer_speed, .pair_a, .pair_b,
        .conn_detect, .tones_seen, .speed_neg_done, .neg_speed, .bias_input,
        .signal_valid, .tones_only, .dc_detect);
    // Short debounce keeps the run brief; expectations wait accordingly
    psp_port_page #(.NPORTS(N), .DEBOUNCE_TICKS(4), .BIAS_TICKS(1))
        psp_port_page_inst (.ref_clk, .nrst, .addr, .wr_data, .wr_en, .rd_en,
        .rd_data, .bus_reset, .tree_id_done, .pair_a, .pair_b, .child_role,
        .suspended, .fast_link_mode, .conn_detect, .tones_seen,
        .speed_neg_done, .neg_speed, .self_id_strobe, .self_id_speed,
        .bias_input, .signal_valid, .tones_only, .dc_detect, .port_event,
        .port_event_ack, .resume_fault, .suspend_fault, .standby_error,
        .in_standby, .remote_standby_clear, .port_off_control, .scrambler_off,
        .hold_suspended, .standby_err_clear, .port_event_irq_flag,
        .child_flag_valid);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (standby_err_clear === 3'b010)
            clr_seen++;
        if (cycles == CEIL) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk(input psp_data_type got, input psp_data_type e,
                       input psp_data_type m);
        total_checks++;
        if ((got & m) !== (e & m)) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got & m,
                     e & m);
        end
    endtask : chk

    task automatic wr(input psp_addr_type a, input psp_data_type v);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    task automatic rc(input psp_addr_type a, input psp_data_type e,
                      input psp_data_type m);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, e, m);
    endtask : rc

    task automatic rst();
        @(posedge ref_clk) nrst <= 1'b0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
    endtask : rst

    initial begin
        {nrst, wr_en, rd_en, bus_reset, tree_id_done, port_event_ack} = '0;
        {addr, wr_data, suspended, fast_link_mode, self_id_strobe, plug} = '0;
        {port_event, resume_fault, suspend_fault, standby_error} = '0;
        {in_standby, remote_standby_clear, self_id_speed, offer_speed} = '0;
        child_role = 3'b110;
        line_code = 6'h3f;
        rst();
        rc(4'h7, 8'h00, 8'hff);
        rc(4'h8, 8'hf8, 8'hff);
        rc(4'h9, 8'h00, 8'hff);
        rc(4'hb, 8'h00, 8'hff);
        wr(4'h7, 8'h01);
        for (int c = 0; c < 4; c++) begin
            @(posedge ref_clk) line_code[3:2] <= 2'(c);
            rc(4'h8, {2'(c), c[0], c[1], 4'h0}, 8'hf0);
        end
        @(posedge ref_clk);
        fast_link_mode <= 3'b100;
        plug <= 3'b101;
        offer_speed <= 9'h0c0;
        wr(4'h7, 8'h02);
        rc(4'h8, 8'h00, 8'h06);
        wr(4'h7, 8'h00);
        rc(4'h8, 8'h00, 8'h04);
        repeat (1500) @(posedge ref_clk);
        tree_id_done <= 1'b1;
        self_id_speed <= 9'h002;
        self_id_strobe <= 3'b001;
        @(posedge ref_clk) {tree_id_done, self_id_strobe} <= '0;
        rc(4'h8, 8'h06, 8'h0f);
        rc(4'ha, 8'h80, 8'hff);
        rc(4'h9, 8'h40, 8'hff);
        @(posedge ref_clk) self_id_speed <= 9'h006;
        self_id_strobe <= 3'b001;
        @(posedge ref_clk) self_id_strobe <= 3'b000;
        rc(4'h9, 8'h40, 8'he1);
        wr(4'h7, 8'h02);
        rc(4'h8, 8'h0e, 8'h0f);
        rc(4'h9, 8'h60, 8'hff);
        rc(4'ha, 8'h00, 8'hff);
        wr(4'h7, 8'h01);
        wr(4'h9, 8'h12);
        wr(4'h8, 8'h01);
        chk(8'(port_off_control), 8'h02, 8'hff);
        chk(8'(scrambler_off), 8'h02, 8'hff);
        @(posedge ref_clk) bus_reset <= 1'b1;
        @(posedge ref_clk) bus_reset <= 1'b0;
        #1 chk(8'(child_flag_valid), 8'h00, 8'hff);
        rc(4'h9, 8'h12, 8'hff);
        chk(8'(port_off_control), 8'h02, 8'hff);
        wr(4'h7, 8'h00);
        rc(4'h8, 8'h0e, 8'h0f);
        rc(4'h9, 8'h40, 8'hff);
        @(posedge ref_clk) port_event <= 3'b001;
        @(posedge ref_clk) port_event <= 3'b000;
        #1 chk(8'(port_event_irq_flag), 8'h00, 8'hff);
        @(posedge ref_clk) port_event <= 3'b010;
        @(posedge ref_clk) port_event <= 3'b000;
        #1 chk(8'(port_event_irq_flag), 8'h01, 8'hff);
        // Event and acknowledge together: the event must win
        @(posedge ref_clk) port_event <= 3'b010;
        port_event_ack <= 1'b1;
        @(posedge ref_clk) port_event <= 3'b000;
        port_event_ack <= 1'b0;
        #1 chk(8'(port_event_irq_flag), 8'h01, 8'hff);
        @(posedge ref_clk) port_event_ack <= 1'b1;
        @(posedge ref_clk) port_event_ack <= 1'b0;
        #1 chk(8'(port_event_irq_flag), 8'h00, 8'hff);
        wr(4'h7, 8'h01);
        @(posedge ref_clk) resume_fault <= 3'b010;
        @(posedge ref_clk) resume_fault <= 3'b000;
        rc(4'h9, 8'h1a, 8'hff);
        chk(8'(hold_suspended), 8'h02, 8'hff);
        wr(4'h9, 8'h12);
        rc(4'h9, 8'h1a, 8'hff);
        @(posedge ref_clk) suspend_fault <= 3'b010;
        @(posedge ref_clk) suspend_fault <= 3'b000;
        wr(4'h9, 8'h1a);
        rc(4'h9, 8'h12, 8'hff);
        @(posedge ref_clk) in_standby <= 3'b010;
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk) standby_error <= 3'b010;
            @(posedge ref_clk) standby_error <= 3'b000;
            rc(4'h9, 8'h16, 8'hff);
            if (k == 0)
                wr(4'h9, 8'h16);
            @(posedge ref_clk) remote_standby_clear <= k == 1 ? 3'b010 : 3'b000;
            in_standby <= k == 2 ? 3'b000 : 3'b010;
            @(posedge ref_clk) remote_standby_clear <= 3'b000;
            rc(4'h9, 8'h12, 8'hff);
        end
        chk(8'(clr_seen), 8'h02, 8'hff);
        wr(4'h7, 8'h03);
        wr(4'h8, 8'h01);
        for (int a = 8; a < 11; a++)
            rc(4'(a), 8'h00, 8'hff);
        chk(8'(port_off_control), 8'h02, 8'hff);
        wr(4'h7, 8'h21);
        rc(4'h9, 8'h00, 8'hff);
        rst();
        chk(8'({port_off_control, scrambler_off}), 8'h00, 8'hff);
        rc(4'h8, 8'h08, 8'h0c);
        finish_test();
    end
endmodule : test_psp_port_page
